// [rtl/hcs_status_reg.sv]
/*
  Channel 2 host interface status register with its data bytes.
  Assumes host cycle fields are stable around link clock rising edges
  and that slave strobes are one-cycle pulses on clock_i.
*/
// Overview of operation
// [R1] A host write to the input data byte latches address bit 2 as cmd/data.
// [R2] A host write to the input data byte sets input-buffer-full.
// [R3] Input-buffer-full drives the slave interrupt request while set.
// [R4] A slave read of the input data byte clears input-buffer-full.
// [R5] In fast gate mode the gate command and its data leave the flag alone.
// [R6] A slave write of the output data byte sets output-buffer-full.
// [R7] A host read of the output data byte clears output-buffer-full.
// [R8] A slave write of 0 to bit 0 clears output-buffer-full.
// [R9] A slave write of 1 to bit 0 leaves output-buffer-full unchanged.
// [R10] Bits 7 to 4 and bit 2 are slave read/write, host read-only flags.
// [R11] A host read at the status address returns the status byte.
// [R12] The status byte comes out of reset as all zero.
// [R13] Slave writes keep cmd/data and input-full; host writes leave bits 7 to 4 and bit 2 alone.
`timescale 1ns/1ps

module hcs_status_reg (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        lpc_clk_i,
  input  wire logic        host_valid_i,
  input  wire logic        host_write_i,
  input  wire logic [15:0] host_addr_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  output logic             host_ack_o,
  input  wire logic        slv_wr_i,
  input  wire logic        slv_rd_i,
  input  wire logic [1:0]  slv_sel_i,
  input  wire logic [7:0]  slv_wdata_i,
  output logic      [7:0]  slv_rdata_o,
  output logic             ibf_irq_o,
  input  wire logic        fast_a20_en_i,
  output logic             gate_a20_o
);

  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [15:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction : addr_hit

  // Link side synchronisers
  logic                   lclk_s1_r;
  logic                   lclk_s2_r;
  logic                   lclk_d_r;
  hcs_pkg::hcs_host_req_t req_s1_r;
  hcs_pkg::hcs_host_req_t req_s2_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_d_r  <= 1'b0;
      req_s1_r  <= hcs_pkg::HOST_REQ_IDLE;
      req_s2_r  <= hcs_pkg::HOST_REQ_IDLE;
    end else begin
      lclk_s1_r <= lpc_clk_i;
      lclk_s2_r <= lclk_s1_r;
      lclk_d_r  <= lclk_s2_r;
      req_s1_r  <= '{valid: host_valid_i, write: host_write_i,
                     addr: host_addr_i, data: host_wdata_i};
      req_s2_r  <= req_s1_r;
    end
  end

  // Host cycle decode
  hcs_pkg::hcs_status_t status_r;
  logic [7:0]           idr_r;
  logic [7:0]           odr_r;
  logic                 a20_pend_r;
  logic                 gate_a20_r;
  logic                 host_evt;
  logic                 host_idr_wr;
  logic                 host_is_cmd;
  logic                 a20_absorb;
  logic                 ibf_set;
  logic                 host_odr_rd;
  logic                 host_sts_rd;
  logic                 slv_sts_wr;
  logic                 slv_idr_rd;
  logic                 slv_odr_wr;
  logic                 obf_sw_clr;
  hcs_pkg::hcs_status_t slv_wr_view;

  assign host_evt    = lclk_s2_r & ~lclk_d_r & req_s2_r.valid;
  assign host_is_cmd = req_s2_r.addr[hcs_pkg::ADDR_CD_BIT];
  assign host_idr_wr = host_evt & req_s2_r.write &
                       (addr_hit(req_s2_r.addr, hcs_pkg::HOST_ADDR_DATA) |
                        addr_hit(req_s2_r.addr, hcs_pkg::HOST_ADDR_CMD));
  assign host_odr_rd = host_evt & ~req_s2_r.write &
                       addr_hit(req_s2_r.addr, hcs_pkg::HOST_ADDR_DATA);
  assign host_sts_rd = host_evt & ~req_s2_r.write &
                       addr_hit(req_s2_r.addr, hcs_pkg::HOST_ADDR_CMD);
  assign a20_absorb  = fast_a20_en_i & host_idr_wr &
                       ((host_is_cmd &
                         (req_s2_r.data == hcs_pkg::A20_CMD_CODE)) |
                        (~host_is_cmd & a20_pend_r)); // R5
  assign ibf_set     = host_idr_wr & ~a20_absorb; // R2 R5

  // Slave strobes
  assign slv_wr_view = slv_wdata_i;
  assign slv_sts_wr = slv_wr_i & (slv_sel_i == hcs_pkg::SLV_SEL_STATUS);
  assign slv_odr_wr = slv_wr_i & (slv_sel_i == hcs_pkg::SLV_SEL_ODR);
  assign slv_idr_rd = slv_rd_i & (slv_sel_i == hcs_pkg::SLV_SEL_IDR);
  assign obf_sw_clr = slv_sts_wr & ~slv_wdata_i[hcs_pkg::STS_OBF_BIT]; // R8 R9

  // Status flags
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_r <= hcs_pkg::STATUS_RESET; // R12
    end else begin
      if (slv_sts_wr) begin
        status_r.user_hi <= slv_wr_view.user_hi; // R10
        status_r.user_b2 <= slv_wr_view.user_b2; // R10
      end
      if (host_idr_wr) begin
        status_r.cmd_data <= host_is_cmd; // R1 R13
      end
      if (ibf_set) begin
        status_r.in_buf_full_flag <= 1'b1; // R2
      end else if (slv_idr_rd) begin
        status_r.in_buf_full_flag <= 1'b0; // R4
      end
      if (slv_odr_wr) begin
        status_r.out_buf_full_flag <= 1'b1; // R6
      end else if (host_odr_rd | obf_sw_clr) begin
        status_r.out_buf_full_flag <= 1'b0; // R7 R8
      end
    end
  end

  // Data bytes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idr_r <= hcs_pkg::BYTE_ZERO;
      odr_r <= hcs_pkg::BYTE_ZERO;
    end else begin
      if (ibf_set) begin
        idr_r <= req_s2_r.data;
      end
      if (slv_odr_wr) begin
        odr_r <= slv_wdata_i;
      end
    end
  end

  // Fast gate sequence
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a20_pend_r <= 1'b0;
      gate_a20_r <= 1'b0;
    end else if (host_idr_wr) begin
      a20_pend_r <= fast_a20_en_i & host_is_cmd &
                    (req_s2_r.data == hcs_pkg::A20_CMD_CODE); // R5
      if (a20_absorb & ~host_is_cmd) begin
        gate_a20_r <= req_s2_r.data[hcs_pkg::A20_GATE_BIT]; // R5
      end
    end
  end

  // Read answers
  logic [7:0] host_rdata_r;
  logic       host_ack_r;
  logic [7:0] slv_rdata_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_rdata_r <= hcs_pkg::BYTE_ZERO;
      host_ack_r   <= 1'b0;
    end else begin
      host_ack_r <= host_odr_rd | host_sts_rd;
      if (host_sts_rd) begin
        host_rdata_r <= status_r; // R11
      end else if (host_odr_rd) begin
        host_rdata_r <= odr_r;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slv_rdata_r <= hcs_pkg::BYTE_ZERO;
    end else if (slv_rd_i) begin
      case (slv_sel_i)
        hcs_pkg::SLV_SEL_STATUS: slv_rdata_r <= status_r;
        hcs_pkg::SLV_SEL_IDR:    slv_rdata_r <= idr_r;
        hcs_pkg::SLV_SEL_ODR:    slv_rdata_r <= odr_r;
        default:                 slv_rdata_r <= hcs_pkg::BYTE_ZERO;
      endcase
    end
  end

  assign host_rdata_o = host_rdata_r;
  assign host_ack_o   = host_ack_r;
  assign slv_rdata_o  = slv_rdata_r;
  assign ibf_irq_o    = status_r.in_buf_full_flag; // R3
  assign gate_a20_o   = gate_a20_r;

  // Checks
  cd_latch_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R1
    host_idr_wr |=> status_r.cmd_data == $past(host_is_cmd))
    else $error("cmd/data not latched from address");

  ibf_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R2
    ibf_set |=> status_r.in_buf_full_flag ##1 (status_r.in_buf_full_flag || $past(slv_idr_rd)))
    else $error("input full not set by host write");

  irq_src_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R3
    $rose(ibf_irq_o) |-> $past(host_idr_wr))
    else $error("interrupt rose without host write");

  ibf_clr_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R4
    slv_idr_rd && !ibf_set |=> !ibf_irq_o)
    else $error("input full not cleared by slave read");

  a20_keep_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R5
    a20_absorb && !slv_idr_rd |=> $stable(status_r.in_buf_full_flag))
    else $error("fast gate write changed input full");

  obf_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R6
    slv_odr_wr |=> status_r.out_buf_full_flag)
    else $error("output full not set by slave write");

  obf_host_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R7
    host_odr_rd && !slv_odr_wr |=> !status_r.out_buf_full_flag && host_ack_o)
    else $error("output full not cleared by host read");

  obf_sw_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R8
    slv_sts_wr && !slv_wr_view.out_buf_full_flag |=> !status_r.out_buf_full_flag)
    else $error("output full not cleared by slave zero");

  obf_keep_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R9
    slv_sts_wr && slv_wr_view.out_buf_full_flag && !host_odr_rd
      |=> status_r.out_buf_full_flag == $past(status_r.out_buf_full_flag))
    else $error("slave one changed output full");

  user_wr_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R10
    slv_sts_wr |=> {status_r.user_hi, status_r.user_b2}
      == {$past(slv_wr_view.user_hi), $past(slv_wr_view.user_b2)})
    else $error("user flags not written");

  sts_read_a: assert property ( // R11
    @(posedge clock_i) disable iff (!resetn_i)
    host_sts_rd |=> host_ack_o && host_rdata_o == $past(status_r))
    else $error("host status read mismatch");

  no_host_wr_a: assert property ( // R13
    @(posedge clock_i) disable iff (!resetn_i)
    host_idr_wr && !slv_sts_wr
      |=> $stable({status_r.user_hi, status_r.user_b2}))
    else $error("host write altered user flags");

  reset_val_a: assert property (@(posedge clock_i) // R12
    $rose(resetn_i) |-> status_r == hcs_pkg::STATUS_RESET)
    else $error("status byte not zero after reset");

  odr_ans_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R7
    host_odr_rd |=> host_ack_o && host_rdata_o == $past(odr_r))
    else $error("host data read mismatch");

  cd_keep_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R13
    slv_wr_i && !host_idr_wr && !slv_idr_rd
      |=> $stable({status_r.cmd_data, status_r.in_buf_full_flag}))
    else $error("slave write altered host flags");

  idr_load_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R2
    ibf_set |=> idr_r == $past(req_s2_r.data))
    else $error("input data byte not stored");

  odr_load_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R6
    slv_odr_wr |=> odr_r == $past(slv_wdata_i))
    else $error("output data byte not stored");

  gate_out_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R5
    a20_absorb && !host_is_cmd
      |=> gate_a20_o == $past(req_s2_r.data[hcs_pkg::A20_GATE_BIT]))
    else $error("gate level not taken from data byte");

  slv_sts_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R10
    slv_rd_i && slv_sel_i == hcs_pkg::SLV_SEL_STATUS
      |=> slv_rdata_o == $past(status_r))
    else $error("slave status read mismatch");

  ack_read_a: assert property ( // R11
    @(posedge clock_i) disable iff (!resetn_i)
    host_evt && req_s2_r.write |=> !host_ack_o)
    else $error("host write drew an answer");

  cmd_wr_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    host_idr_wr && host_is_cmd);
  ibf_cycle_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    ibf_set ##[1:200] slv_idr_rd);
  obf_cycle_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    slv_odr_wr ##[1:200] host_odr_rd);
  a20_seq_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    a20_absorb && !host_is_cmd);
  obf_clr_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    obf_sw_clr && status_r.out_buf_full_flag);

endmodule : hcs_status_reg

// [rtl/hcs_pkg.sv]
/*
  Constants and carrier types for the channel 2 host status register.
  Assumes host cycles are already framed into address, data and a
  cycle-valid level, held across at least one link clock rising edge.
*/
package hcs_pkg;

  // Host I/O addresses of the channel
  localparam logic [15:0] HOST_ADDR_DATA = 16'h0062;
  localparam logic [15:0] HOST_ADDR_CMD  = 16'h0066;
  localparam int          ADDR_CD_BIT    = 2;

  // Status bit positions
  localparam int STS_OBF_BIT = 0;
  localparam int STS_IBF_BIT = 1;

  // Slave register selects
  localparam logic [1:0] SLV_SEL_STATUS = 2'h0;
  localparam logic [1:0] SLV_SEL_IDR    = 2'h1;
  localparam logic [1:0] SLV_SEL_ODR    = 2'h2;

  // Fast gate control
  localparam logic [7:0] A20_CMD_CODE = 8'hD1;
  localparam int         A20_GATE_BIT = 1;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic [3:0] user_hi;
    logic       cmd_data;
    logic       user_b2;
    logic       in_buf_full_flag;
    logic       out_buf_full_flag;
  } hcs_status_t;

  localparam hcs_status_t STATUS_RESET = hcs_status_t'(8'h00);

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } hcs_host_req_t;

  localparam hcs_host_req_t HOST_REQ_IDLE = hcs_host_req_t'(26'h0000000);

endpackage : hcs_pkg

// [tb/hcs_host_model.sv]
/*
  Host side model: frames one host I/O cycle per link clock rise.
  Assumes the device answers a read within the link clock high phase.
*/
`timescale 1ns/1ps

module hcs_host_model (
  input  wire logic                    clock_i,
  input  wire logic                    host_ack_i,
  input  wire logic [7:0]              host_rdata_i,
  output logic                         lpc_clk_o,
  output hcs_pkg::hcs_host_req_t       req_o
);
  logic [7:0] last_q;
  int         acks;

  initial begin
    lpc_clk_o = 1'b0;
    req_o     = hcs_pkg::HOST_REQ_IDLE;
    acks      = 0;
  end

  // Read answer taken at the edge where ack is high
  always @(posedge clock_i) begin
    if (host_ack_i === 1'b1) begin
      last_q = host_rdata_i;
      acks   = acks + 1;
    end
  end

  // Link clock runs only inside a cycle
  task automatic cycle(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
    int a0;
    a0    = acks;
    req_o = '{valid: 1'b1, write: w, addr: a, data: d};
    #80 lpc_clk_o = 1'b1;
    #80 lpc_clk_o = 1'b0;
    // Released lines show the inverse of the last value
    req_o = '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
    q     = (acks != a0) ? last_q : 8'hXX;
    #80;
  endtask : cycle
endmodule : hcs_host_model

// [tb/hcs_status_reg_tb.sv]
/*
  Self-checking bench for the channel 2 status register.
  Assumes the host model and the design package are compiled first.
*/
`timescale 1ns/1ps

module hcs_status_reg_tb;
  logic                   clock_i;
  logic                   resetn_i;
  logic                   lpc_clk;
  hcs_pkg::hcs_host_req_t req;
  logic                   slv_wr_i;
  logic                   slv_rd_i;
  logic [1:0]             slv_sel_i;
  logic [7:0]             slv_wdata_i;
  logic [7:0]             slv_rdata_o;
  logic [7:0]             host_rdata;
  logic                   host_ack;
  logic                   ibf_irq_o;
  logic                   fast_a20_en_i;
  logic                   gate_a20_o;
  logic [7:0]             exp_s;
  logic [7:0]             q;
  logic [7:0]             d;
  logic [7:0]             o;
  logic [15:0]            a;
  int                     bad_count;
  int                     comparisons;

  hcs_status_reg u_hcs_status_reg (
    .clock_i(clock_i), .resetn_i(resetn_i), .lpc_clk_i(lpc_clk),
    .host_valid_i(req.valid), .host_write_i(req.write),
    .host_addr_i(req.addr), .host_wdata_i(req.data),
    .host_rdata_o(host_rdata), .host_ack_o(host_ack),
    .slv_wr_i(slv_wr_i), .slv_rd_i(slv_rd_i), .slv_sel_i(slv_sel_i),
    .slv_wdata_i(slv_wdata_i), .slv_rdata_o(slv_rdata_o),
    .ibf_irq_o(ibf_irq_o), .fast_a20_en_i(fast_a20_en_i),
    .gate_a20_o(gate_a20_o)
  );

  hcs_host_model u_host (
    .clock_i(clock_i), .host_ack_i(host_ack),
    .host_rdata_i(host_rdata), .lpc_clk_o(lpc_clk), .req_o(req)
  );

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Slave write: user bits taken, 3 and 1 kept, bit 0 clear only
  function automatic logic [7:0] slv_sts(input logic [7:0] s,
                                         input logic [7:0] v);
    return {v[7:4], s[3], v[2], s[1], s[0] & v[0]};
  endfunction : slv_sts

  // Host input write: cmd/data from address, input full set
  function automatic logic [7:0] host_wr(input logic [7:0] s,
                                         input logic [15:0] ad);
    return {s[7:4], ad[hcs_pkg::ADDR_CD_BIT], s[2], 1'b1, s[0]};
  endfunction : host_wr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic sreq(input logic w, input logic [1:0] s,
                      input logic [7:0] v);
    @(posedge clock_i);
    #1;
    slv_wr_i    = w;
    slv_rd_i    = ~w;
    slv_sel_i   = s;
    slv_wdata_i = v;
    @(posedge clock_i);
    #1;
    slv_wr_i = 1'b0;
    slv_rd_i = 1'b0;
  endtask : sreq

  task automatic ck_sts();
    logic [7:0] hq;
    sreq(1'b0, hcs_pkg::SLV_SEL_STATUS, 8'h00);
    chk(slv_rdata_o, exp_s);
    u_host.cycle(1'b0, hcs_pkg::HOST_ADDR_CMD, 8'h00, hq);
    chk(hq, exp_s);
  endtask : ck_sts

  task automatic wrap_up();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end

  initial begin
    resetn_i = 1'b0;
    {slv_wr_i, slv_rd_i, slv_sel_i, slv_wdata_i} = 12'h000;
    fast_a20_en_i = 1'b0;
    bad_count = 0;
    comparisons = 0;
    exp_s = hcs_pkg::STATUS_RESET;
    void'($urandom(32'h9BF6));
    repeat (10) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    ck_sts();
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      sreq(1'b1, hcs_pkg::SLV_SEL_STATUS, d);
      exp_s = slv_sts(exp_s, d);
      ck_sts();
      a = $urandom_range(0, 1) ? hcs_pkg::HOST_ADDR_CMD
                               : hcs_pkg::HOST_ADDR_DATA;
      o = 8'($urandom);
      u_host.cycle(1'b1, a, o, q);
      exp_s = host_wr(exp_s, a);
      chk({7'h00, ibf_irq_o}, 8'h01);
      ck_sts();
      d = 8'($urandom);
      sreq(1'b1, hcs_pkg::SLV_SEL_STATUS, d);
      exp_s = slv_sts(exp_s, d);
      ck_sts();
      sreq(1'b0, hcs_pkg::SLV_SEL_IDR, 8'h00);
      chk(slv_rdata_o, o);
      exp_s[1] = 1'b0;
      chk({7'h00, ibf_irq_o}, 8'h00);
      d = 8'($urandom);
      sreq(1'b1, hcs_pkg::SLV_SEL_ODR, d);
      exp_s[0] = 1'b1;
      sreq(1'b1, hcs_pkg::SLV_SEL_STATUS, exp_s);
      ck_sts();
      u_host.cycle(1'b0, hcs_pkg::HOST_ADDR_DATA, 8'h00, q);
      chk(q, d);
      exp_s[0] = 1'b0;
      ck_sts();
      sreq(1'b1, hcs_pkg::SLV_SEL_ODR, d);
      sreq(1'b1, hcs_pkg::SLV_SEL_STATUS, exp_s & 8'hFE);
      ck_sts();
    end
    sreq(1'b1, hcs_pkg::SLV_SEL_IDR, 8'($urandom));
    u_host.cycle(1'b1, 16'h0060, 8'($urandom), q);
    ck_sts();
    sreq(1'b0, hcs_pkg::SLV_SEL_IDR, 8'h00);
    chk(slv_rdata_o, o);
    sreq(1'b0, 2'h3, 8'h00);
    chk(slv_rdata_o, hcs_pkg::BYTE_ZERO);
    fast_a20_en_i = 1'b1;
    u_host.cycle(1'b1, hcs_pkg::HOST_ADDR_CMD, hcs_pkg::A20_CMD_CODE, q);
    u_host.cycle(1'b1, hcs_pkg::HOST_ADDR_DATA, 8'h02, q);
    exp_s[3] = 1'b0;
    ck_sts();
    chk({7'h00, gate_a20_o}, 8'h01);
    sreq(1'b0, hcs_pkg::SLV_SEL_IDR, 8'h00);
    chk(slv_rdata_o, o);
    u_host.cycle(1'b1, hcs_pkg::HOST_ADDR_CMD, hcs_pkg::A20_CMD_CODE, q);
    u_host.cycle(1'b1, hcs_pkg::HOST_ADDR_DATA, 8'h00, q);
    chk({7'h00, gate_a20_o}, 8'h00);
    fast_a20_en_i = 1'b0;
    wrap_up();
  end
endmodule : hcs_status_reg_tb
